// >>> rtl/ewc_pkg.sv
// Package for the emission wakeup controller: constants, register map and field layout
package ewc_pkg;
	localparam int NUM_SOURCES = 4;
	localparam int SRC_W = 2;
	localparam int TYPE_W = 8;
	localparam logic [TYPE_W-1:0] TYPE_SIG_MIN = 8'h01;
	localparam logic [TYPE_W-1:0] TYPE_SIG_MAX = 8'h05;
	localparam int CTRL_ACTIVE_BIT = 1;
	localparam int CTRL_ALERT_BIT = 0;
	localparam logic [1:0] WAKE_OFF = 2'h0;
	localparam logic [1:0] WAKE_FIRST = 2'h1;
	localparam logic [1:0] WAKE_LAST = 2'h3;
	localparam logic [1:0] WAKE_STEP = 2'h1;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
	localparam logic [ADDR_W-1:0] REG_COUNT = 4'h2;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_FLUSH_BIT = 1;
	localparam int CTRL_OVERRIDE_BIT = 2;
	localparam int STAT_FIELD_LSB = 0;
	localparam int STAT_SRC_LSB = 4;
	localparam int CNT_W = 16;
	localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000001;
	typedef enum logic [1:0] {EWC_IDLE, EWC_LOAD} ewc_pkt_state_type;
endpackage

// >>> rtl/ewc_source_slot.sv
// One per-source wakeup-active holder
`timescale 1ns/100ps
module ewc_source_slot (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic upd_in,
	input wire logic active_in,
	input wire logic flush_in,
	output logic active_out
);
	logic active_r;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			active_r <= 1'b0;
		end else if (flush_in) begin
			active_r <= 1'b0;
		end else if (upd_in) begin
			// Source restates its state on every signaling packet, so last word wins
			active_r <= active_in;
		end
	end
	assign active_out = active_r;
endmodule

// >>> rtl/ewc_top.sv
// Emission wakeup controller top: packet intake, source merge, field stepping, registers
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
module ewc_top (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic pkt_valid_in,
	input wire logic [ewc_pkg::TYPE_W-1:0] pkt_type_in,
	input wire logic [ewc_pkg::SRC_W-1:0] pkt_src_in,
	input wire logic [1:0] pkt_wakeup_ctrl_in,
	input wire logic [ewc_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [ewc_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [ewc_pkg::DATA_W-1:0] reg_rdata_out,
	output logic preamble_wake_bit_one_out,
	output logic preamble_wake_bit_two_out,
	output logic wake_on_out
);
	ewc_pkg::ewc_pkt_state_type state_r;
	logic [ewc_pkg::TYPE_W-1:0] type_r;
	logic [ewc_pkg::SRC_W-1:0] src_r;
	logic [1:0] ctrl_r;
	logic [ewc_pkg::DATA_W-1:0] ctrl_reg_r;
	logic [1:0] field_r;
	logic [1:0] field_nxt;
	logic combined_r;
	logic [ewc_pkg::CNT_W-1:0] alert_cnt_r;
	logic [ewc_pkg::DATA_W-1:0] rdata_r;
	logic [ewc_pkg::NUM_SOURCES-1:0] src_active;
	logic [ewc_pkg::NUM_SOURCES-1:0] src_upd;
	logic sig_type;
	logic load;
	logic alert;
	logic combined;
	logic enable;
	logic flush;
	logic override;

	assign enable = ctrl_reg_r[ewc_pkg::CTRL_ENABLE_BIT];
	assign override = ctrl_reg_r[ewc_pkg::CTRL_OVERRIDE_BIT];
	assign flush = reg_wr_in && (reg_addr_in == ewc_pkg::REG_CTRL)
		&& reg_wdata_in[ewc_pkg::CTRL_FLUSH_BIT];

	// Packet header is registered once so the field update sees stable values
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= ewc_pkg::EWC_IDLE;
		end else begin
			case (state_r)
				ewc_pkg::EWC_IDLE: begin
					if (pkt_valid_in && enable) begin
						state_r <= ewc_pkg::EWC_LOAD;
					end
				end
				ewc_pkg::EWC_LOAD: begin
					if (!(pkt_valid_in && enable)) begin
						state_r <= ewc_pkg::EWC_IDLE;
					end
				end
				default: begin
					state_r <= ewc_pkg::EWC_IDLE;
				end
			endcase
		end
	end

	// Header only moves on a taken packet, so idle lines never reach the slots
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			type_r <= '0;
			src_r <= '0;
			ctrl_r <= '0;
		end else if (pkt_valid_in && enable) begin
			type_r <= pkt_type_in;
			src_r <= pkt_src_in;
			ctrl_r <= pkt_wakeup_ctrl_in;
		end
	end

	assign sig_type = (type_r >= ewc_pkg::TYPE_SIG_MIN)
		&& (type_r <= ewc_pkg::TYPE_SIG_MAX);
	assign load = (state_r == ewc_pkg::EWC_LOAD) && sig_type;
	// Alert flag only counts on a valid signaling packet from an active source
	assign alert = load && ctrl_r[ewc_pkg::CTRL_ALERT_BIT]
		&& ctrl_r[ewc_pkg::CTRL_ACTIVE_BIT];

	genvar gi;
	generate
		for (gi = 0; gi < ewc_pkg::NUM_SOURCES; gi++) begin : g_src
			assign src_upd[gi] = load && (src_r == ewc_pkg::SRC_W'(gi));
			ewc_source_slot u_slot (
				.sys_clk_in(sys_clk_in),
				.rst_n_in(rst_n_in),
				.upd_in(src_upd[gi]),
				.active_in(ctrl_r[ewc_pkg::CTRL_ACTIVE_BIT]),
				.flush_in(flush),
				.active_out(src_active[gi])
			);
		end
	endgenerate

	// A source clearing its bit only drops the field if every other source bit and the override bit are clear
	assign combined = (|src_active) || override;

	always_comb begin
		field_nxt = field_r;
		if (!combined) begin
			field_nxt = ewc_pkg::WAKE_OFF;
		end else if (field_r == ewc_pkg::WAKE_OFF) begin
			// Off-to-on starts at 1, with or without an alert on this packet
			field_nxt = ewc_pkg::WAKE_FIRST;
		end else if (alert) begin
			if (field_r == ewc_pkg::WAKE_LAST) begin
				field_nxt = ewc_pkg::WAKE_FIRST;
			end else begin
				field_nxt = field_r + ewc_pkg::WAKE_STEP;
			end
		end
	end

	// Preamble bits load from field_nxt on the same edge as the field, so they always match it
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			field_r <= ewc_pkg::WAKE_OFF;
		end else begin
			field_r <= field_nxt;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			combined_r <= 1'b0;
		end else begin
			combined_r <= combined;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			preamble_wake_bit_one_out <= 1'b0;
			preamble_wake_bit_two_out <= 1'b0;
		end else begin
			preamble_wake_bit_one_out <= field_nxt[1];
			preamble_wake_bit_two_out <= field_nxt[0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wake_on_out <= 1'b0;
		end else begin
			wake_on_out <= combined;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_reg_r <= ewc_pkg::CTRL_RESET;
		end else if (reg_wr_in && reg_addr_in == ewc_pkg::REG_CTRL) begin
			// Flush bit is self-clearing and never stored
			ctrl_reg_r <= reg_wdata_in;
			ctrl_reg_r[ewc_pkg::CTRL_FLUSH_BIT] <= 1'b0;
		end
	end

	// Count of accepted alerts; a write to the counter clears it, a coincident alert wins
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			alert_cnt_r <= '0;
		end else if (alert && combined) begin
			alert_cnt_r <= alert_cnt_r + 16'h0001;
		end else if (reg_wr_in && reg_addr_in == ewc_pkg::REG_COUNT) begin
			alert_cnt_r <= '0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_r <= '0;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				ewc_pkg::REG_CTRL: rdata_r <= ctrl_reg_r;
				ewc_pkg::REG_STATUS: begin
					rdata_r <= '0;
					rdata_r[ewc_pkg::STAT_FIELD_LSB +: 2] <= field_r;
					rdata_r[ewc_pkg::STAT_SRC_LSB +: ewc_pkg::NUM_SOURCES] <= src_active;
				end
				ewc_pkg::REG_COUNT: rdata_r <= ewc_pkg::DATA_W'(alert_cnt_r);
				default: rdata_r <= '0;
			endcase
		end else begin
			rdata_r <= '0;
		end
	end
	assign reg_rdata_out = rdata_r;

	chk_off_when_idle: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		!combined_r |-> field_r == ewc_pkg::WAKE_OFF)
		else $error("field not zero while off");

	chk_on_nonzero: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		combined_r |-> field_r != ewc_pkg::WAKE_OFF)
		else $error("field zero while on");

	chk_alert_step: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(alert && combined && field_r == ewc_pkg::WAKE_FIRST) |=> field_r == ewc_pkg::WAKE_FIRST + ewc_pkg::WAKE_STEP)
		else $error("alert did not advance field");

	chk_alert_third: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(alert && combined && field_r == ewc_pkg::WAKE_FIRST + ewc_pkg::WAKE_STEP) |=> field_r == ewc_pkg::WAKE_LAST)
		else $error("alert did not reach last state");

	chk_wrap_three: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(alert && combined && field_r == ewc_pkg::WAKE_LAST) |=> field_r == ewc_pkg::WAKE_FIRST)
		else $error("field did not wrap to one");

	chk_hold_noalert: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(!alert && combined && field_r != ewc_pkg::WAKE_OFF) |=> $stable(field_r))
		else $error("field moved without alert");

	chk_first_on: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(combined && field_r == ewc_pkg::WAKE_OFF) |=> field_r == ewc_pkg::WAKE_FIRST)
		else $error("turn on did not start at one");

	chk_clear_drops: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(!combined && field_r != ewc_pkg::WAKE_OFF) |=> field_r == ewc_pkg::WAKE_OFF)
		else $error("field stayed on after all requests cleared");

	chk_stay_on: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(combined && field_r != ewc_pkg::WAKE_OFF) |=> field_r != ewc_pkg::WAKE_OFF)
		else $error("field returned to zero while on");

	chk_type_gate: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(state_r == ewc_pkg::EWC_LOAD && !sig_type && !flush) |=> $stable(src_active))
		else $error("non-signaling packet changed state");

	chk_src_hold: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(!load && !flush) |=> $stable(src_active))
		else $error("source bit moved without a packet");

	chk_src_update: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(load && !flush) |=> src_active[$past(src_r)] == $past(ctrl_r[ewc_pkg::CTRL_ACTIVE_BIT]))
		else $error("source bit did not take packet state");

	chk_flush_clear: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		flush |=> src_active == '0)
		else $error("flush left a source bit set");

	chk_merge_or: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(|src_active) |-> ##1 wake_on_out)
		else $error("merged request not shown");

	chk_merge_off: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(!(|src_active) && !override) |=> !wake_on_out)
		else $error("request shown with no source active");

	chk_lone_alert: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(state_r == ewc_pkg::EWC_LOAD && !ctrl_r[ewc_pkg::CTRL_ACTIVE_BIT] && combined && field_r != ewc_pkg::WAKE_OFF) |=> $stable(field_r))
		else $error("alert without active flag moved field");

	chk_pins_unit: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		{preamble_wake_bit_one_out, preamble_wake_bit_two_out} == field_r)
		else $error("preamble bits differ from field");

	chk_pins_on: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		wake_on_out == (preamble_wake_bit_one_out || preamble_wake_bit_two_out))
		else $error("preamble bits disagree with on state");

	chk_disabled_drop: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(pkt_valid_in && !enable) |=> !load)
		else $error("packet taken while disabled");

	chk_count_step: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(alert && combined) |=> alert_cnt_r == $past(alert_cnt_r) + 16'h0001)
		else $error("accepted alert not counted");

	chk_count_clear: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(reg_wr_in && reg_addr_in == ewc_pkg::REG_COUNT && !(alert && combined)) |=> alert_cnt_r == '0)
		else $error("counter write did not clear");

	chk_rdata_idle: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		!reg_rd_in |=> reg_rdata_out == '0)
		else $error("read data shown without a read");

	chk_flush_self: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(reg_wr_in && reg_addr_in == ewc_pkg::REG_CTRL) |=> !ctrl_reg_r[ewc_pkg::CTRL_FLUSH_BIT])
		else $error("flush bit was stored");
endmodule

// >>> verif/ewc_src_model.sv
// Upstream signaling source model driving the packet header inputs
`timescale 1ns/100ps
module ewc_src_model (
	input wire logic sys_clk_in,
	output logic pkt_valid_out,
	output logic [ewc_pkg::TYPE_W-1:0] pkt_type_out,
	output logic [ewc_pkg::SRC_W-1:0] pkt_src_out,
	output logic [1:0] pkt_wakeup_ctrl_out
);
	initial begin
		pkt_valid_out = 1'b0;
		pkt_type_out = 8'h00;
		pkt_src_out = 2'h0;
		pkt_wakeup_ctrl_out = 2'h0;
	end
	// Active flag first, alert flag second; alert also set on packets outside the table
	// Callers repeat each source's active state on all packets of one stream
	task automatic send(input logic [7:0] t, input logic [1:0] s, input logic [1:0] c);
		@(posedge sys_clk_in);
		pkt_valid_out <= 1'b1;
		pkt_type_out <= t;
		pkt_src_out <= s;
		pkt_wakeup_ctrl_out <= c;
	endtask
	// Released header lines are inverted so a stale value is never mistaken for a packet
	task automatic idle();
		@(posedge sys_clk_in);
		pkt_valid_out <= 1'b0;
		pkt_type_out <= ~pkt_type_out;
		pkt_src_out <= ~pkt_src_out;
		pkt_wakeup_ctrl_out <= ~pkt_wakeup_ctrl_out;
	endtask
endmodule

// >>> verif/tb_ewc_top.sv
// Self-checking bench for the emission wakeup controller
`timescale 1ns/100ps
module tb_ewc_top;
	logic sys_clk_in, rst_n_in, pkt_valid_in, reg_wr_in, reg_rd_in, wake_on_out;
	logic preamble_wake_bit_one_out, preamble_wake_bit_two_out;
	logic [ewc_pkg::TYPE_W-1:0] pkt_type_in;
	logic [ewc_pkg::SRC_W-1:0] pkt_src_in;
	logic [1:0] pkt_wakeup_ctrl_in;
	logic [ewc_pkg::ADDR_W-1:0] reg_addr_in;
	logic [ewc_pkg::DATA_W-1:0] reg_wdata_in, reg_rdata_out;
	int error_cnt, check_count;
	// Single-source example sequence: type, control, expected field
	logic [7:0] tbl_t [10] = '{8'h01, 8'h03, 8'h04, 8'h01, 8'h04, 8'h03, 8'h04, 8'h01, 8'h01, 8'h04};
	logic [1:0] tbl_c [10] = '{2'h0, 2'h0, 2'h3, 2'h2, 2'h2, 2'h2, 2'h3, 2'h2, 2'h0, 2'h0};
	logic [1:0] tbl_f [10] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0};
	logic [7:0] bad_t [3] = '{8'h00, 8'h06, 8'hFF};
	ewc_top i_ewc_top (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.pkt_valid_in(pkt_valid_in), .pkt_type_in(pkt_type_in), .pkt_src_in(pkt_src_in),
		.pkt_wakeup_ctrl_in(pkt_wakeup_ctrl_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .preamble_wake_bit_one_out(preamble_wake_bit_one_out),
		.preamble_wake_bit_two_out(preamble_wake_bit_two_out), .wake_on_out(wake_on_out));
	ewc_src_model i_ewc_src_model (.sys_clk_in(sys_clk_in), .pkt_valid_out(pkt_valid_in),
		.pkt_type_out(pkt_type_in), .pkt_src_out(pkt_src_in),
		.pkt_wakeup_ctrl_out(pkt_wakeup_ctrl_in));
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic pkt(input logic [7:0] t, input logic [1:0] s, input logic [1:0] c);
		i_ewc_src_model.send(t, s, c);
		i_ewc_src_model.idle();
	endtask
	// Outputs are levels, so waiting one edge beyond the stated latency is harmless
	task automatic chk(input logic [1:0] f, input logic on);
		repeat (3) @(posedge sys_clk_in);
		#1;
		cmp({30'h0, preamble_wake_bit_one_out, preamble_wake_bit_two_out}, {30'h0, f});
		cmp({31'h0, wake_on_out}, {31'h0, on});
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		cmp(reg_rdata_out, exp);
		// Read data must vanish once its single cycle is over
		@(posedge sys_clk_in);
		#1;
		cmp(reg_rdata_out, 32'h0);
	endtask
	task automatic finish_test();
		if (error_cnt == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#20000;
		error_cnt++;
		finish_test();
	end
	initial begin
		error_cnt = 0;
		check_count = 0;
		rst_n_in = 1'b0;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		reg_addr_in = 4'h0;
		reg_wdata_in = 32'h0;
		repeat (2) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		chk(2'h0, 1'b0);
		rd(ewc_pkg::REG_CTRL, 32'h00000001);
		rd(ewc_pkg::REG_COUNT, 32'h0);
		for (int i = 0; i < 10; i++) begin
			pkt(tbl_t[i], 2'h0, tbl_c[i]);
			chk(tbl_f[i], tbl_f[i] != 2'h0);
		end
		pkt(8'h04, 2'h0, 2'h3);
		chk(2'h1, 1'b1);
		wr(ewc_pkg::REG_COUNT, 32'h0);
		pkt(8'h01, 2'h1, 2'h2);
		chk(2'h1, 1'b1);
		pkt(8'h01, 2'h0, 2'h0);
		chk(2'h1, 1'b1);
		pkt(8'h04, 2'h3, 2'h1);
		chk(2'h1, 1'b1);
		i_ewc_src_model.send(8'h04, 2'h2, 2'h3);
		i_ewc_src_model.send(8'h04, 2'h2, 2'h3);
		i_ewc_src_model.idle();
		chk(2'h3, 1'b1);
		pkt(8'h04, 2'h2, 2'h3);
		chk(2'h1, 1'b1);
		rd(ewc_pkg::REG_STATUS, 32'h00000061);
		rd(ewc_pkg::REG_COUNT, 32'h00000003);
		pkt(8'h01, 2'h1, 2'h0);
		pkt(8'h01, 2'h2, 2'h0);
		chk(2'h0, 1'b0);
		for (int i = 0; i < 3; i++) begin
			pkt(bad_t[i], 2'h0, 2'h3);
			chk(2'h0, 1'b0);
		end
		pkt(8'h05, 2'h0, 2'h3);
		chk(2'h1, 1'b1);
		@(posedge sys_clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		chk(2'h0, 1'b0);
		rd(ewc_pkg::REG_STATUS, 32'h0);
		rd(ewc_pkg::REG_CTRL, 32'h00000001);
		pkt(8'h05, 2'h0, 2'h0);
		wr(ewc_pkg::REG_CTRL, 32'h0);
		pkt(8'h04, 2'h0, 2'h3);
		chk(2'h0, 1'b0);
		wr(ewc_pkg::REG_CTRL, 32'h00000005);
		chk(2'h1, 1'b1);
		wr(ewc_pkg::REG_CTRL, 32'h00000001);
		chk(2'h0, 1'b0);
		pkt(8'h02, 2'h3, 2'h2);
		chk(2'h1, 1'b1);
		wr(ewc_pkg::REG_CTRL, 32'h00000003);
		chk(2'h0, 1'b0);
		rd(ewc_pkg::REG_CTRL, 32'h00000001);
		wr(4'hF, 32'hFFFFFFFF);
		rd(4'hF, 32'h0);
		wr(ewc_pkg::REG_STATUS, 32'h000000FF);
		rd(ewc_pkg::REG_STATUS, 32'h0);
		finish_test();
	end
endmodule
